// ==== ads_pkg.sv ====
// Constants, types and state layout for the amplifier diagnostic and phase-clock configuration
//
// Overview of operation
// - The test tone frequency register is an 8-bit read/write code with 375 Hz per step.
// - The test tone frequency register is at address 0x2A and resets to 0x32 (18.75 kHz).
// - Phase-clock control bit 7 at 0 keeps clock error checking on, at 1 skips it.
// - Phase-clock control bit 4 at 0 reports clock errors, at 1 masks them; it resets to 0.
// - Phase-clock control bit 1 at 0 makes the error non-latching, at 1 latching; it resets to 1.
// - Phase-clock control bit 0 at 0 makes the device a clock target fed from outside, at 1 the controller.
// - The phase-clock control register is at 0x2B, resets to 0x02, and bits 6-5 and 3-2 read zero.
// - The switching frequency is selectable among 1.8 MHz, 2.1 MHz and 2.3 MHz only.
// - Mode control bit 4 pairs channels 1 and 2 and bit 5 pairs channels 3 and 4, independently.
// - Load diagnostics stay available on channel pairs that run as a paralleled bridge.
// - Each channel can be put into line-driver mode by its own bit of mode control.
// - The zero-crossing wait code selects 20, 80, 320 or 1280 us, and the gain steps after it regardless.
package ads_pkg;

	localparam int CLK_MHZ = 100;

	// Register map
	localparam logic [7:0] MODE_ADDR = 8'h00;
	localparam logic [7:0] TFB_ADDR  = 8'h28;
	localparam logic [7:0] TONE_ADDR = 8'h2A;
	localparam logic [7:0] SYNC_ADDR = 8'h2B;
	localparam logic [7:0] STAT_ADDR = 8'h2C;

	// Reset values
	localparam logic [7:0] MODE_RST = 8'h40;
	localparam logic [7:0] TFB_RST  = 8'h00;
	localparam logic [7:0] TONE_RST = 8'h32;
	localparam logic [7:0] SYNC_RST = 8'h02;
	localparam logic [7:0] SYNC_RW_MASK = 8'h93;

	// Field positions
	localparam int MODE_LD_LSB      = 0;
	localparam int MODE_PBTL12_BIT  = 4;
	localparam int MODE_PBTL34_BIT  = 5;
	localparam int MODE_FSW_LSB     = 6;
	localparam int TFB_ZCBYP_BIT    = 4;
	localparam int TFB_OFF_BIT      = 5;
	localparam int TFB_ZCW_LSB      = 6;
	localparam int SYNC_CTRL_BIT    = 0;
	localparam int SYNC_LATCH_BIT   = 1;
	localparam int SYNC_MASK_BIT    = 4;
	localparam int SYNC_SKIP_BIT    = 7;
	localparam int STAT_ERR_BIT     = 0;

	// Switching frequency codes
	localparam logic [1:0] FSW_1M8 = 2'h0;
	localparam logic [1:0] FSW_2M1 = 2'h1;
	localparam logic [1:0] FSW_2M3 = 2'h2;

	// Tone scale and wait times
	localparam int TONE_HZ_PER_LSB = 375;
	localparam int ZC_WAIT_20_US   = 20;
	localparam int ZC_WAIT_80_US   = 80;
	localparam int ZC_WAIT_320_US  = 320;
	localparam int ZC_WAIT_1280_US = 1280;
	localparam int ZC_WAIT_20_CYC  = ZC_WAIT_20_US * CLK_MHZ;
	localparam int ZC_CNT_W        = 18;

	// Phase-clock timing in system clock cycles
	localparam logic [7:0] SYNC_MIN_CYC  = 8'h08;
	localparam logic [7:0] SYNC_MAX_CYC  = 8'h20;
	localparam logic [7:0] SYNC_HALF_CYC = 8'h08;

	// Control bus slave address; base value is arbitrary
	localparam logic [6:0] I2C_BASE_ADDR = 7'h6C;
	localparam logic [2:0] I2C_LAST_BIT  = 3'h7;

	typedef enum logic [2:0] {
		ADS_IDLE,
		ADS_ADDR,
		ADS_ACK,
		ADS_ACK_HOLD,
		ADS_WR,
		ADS_RD,
		ADS_RD_ACK
	} ads_i2c_st_t;

	typedef struct packed {
		logic       standby_n;
		logic [1:0] addr_sel;
		logic       zc_det;
		logic       gain_req;
		logic [3:0] diag_req;
		logic       sync;
		logic       sda;
		logic       scl;
	} ads_pins_t;

	typedef struct packed {
		ads_pins_t              s1;
		ads_pins_t              s2;
		ads_pins_t              d;
		ads_i2c_st_t            st;
		logic [2:0]             bitc;
		logic [7:0]             shf;
		logic [7:0]             ptr;
		logic                   first;
		logic                   rw;
		logic                   sda_oe;
		logic                   sda_out;
		logic [7:0]             mode;
		logic [7:0]             tfb;
		logic [7:0]             tone;
		logic [7:0]             syncc;
		logic [7:0]             perc;
		logic                   sync_bad;
		logic                   err_lat;
		logic                   err;
		logic [7:0]             divc;
		logic                   sync_drv;
		logic                   zc_busy;
		logic [ZC_CNT_W-1:0]    zc_cnt;
		logic                   gain_step;
		logic [1:0]             paralleled_bridge_mode;
		logic [1:0]             fsw;
		logic [3:0]             diag_run;
	} ads_state_t;

endpackage

// ==== ads_config.sv ====
// I2C register bank, phase-clock control and mode settings of the four-channel amplifier
`timescale 1ns/100ps
module ads_config #(
	parameter logic [17:0] ZC_WAIT_80_CYC   = 18'(ads_pkg::ZC_WAIT_80_US * ads_pkg::CLK_MHZ),
	parameter logic [17:0] ZC_WAIT_320_CYC  = 18'(ads_pkg::ZC_WAIT_320_US * ads_pkg::CLK_MHZ),
	parameter logic [17:0] ZC_WAIT_1280_CYC = 18'(ads_pkg::ZC_WAIT_1280_US * ads_pkg::CLK_MHZ)
) (
	input  wire logic       sys_clk_i,
	input  wire logic       rst_i,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe_o,
	input  wire logic [1:0] addr_sel_i,
	input  wire logic       standby_n_i,
	input  wire logic       sync_i,
	output logic            sync_o,
	output logic            sync_oe_o,
	output logic            sync_err_o,
	input  wire logic       gain_req_i,
	input  wire logic       zc_det_i,
	output logic            gain_step_o,
	input  wire logic [3:0] diag_req_i,
	output logic [3:0]      diag_run_o,
	output logic [1:0]      paralleled_bridge_mode_o,
	output logic [3:0]      line_drv_o,
	output logic [1:0]      fsw_sel_o,
	output logic [7:0]      tone_freq_o
);

	ads_pkg::ads_state_t r;
	ads_pkg::ads_state_t n;
	ads_pkg::ads_pins_t  pins;
	logic                scl_rise;
	logic                scl_fall;
	logic                bus_start;
	logic                bus_stop;
	logic                sync_rise;
	logic                err_raw;
	logic [7:0]          byte_in;
	logic [6:0]          own_addr;
	logic [17:0]         zc_load;

	// Register read mux; reserved bits of the phase-clock register read zero
	function automatic logic [7:0] reg_read(input ads_pkg::ads_state_t s, input logic [7:0] a);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			ads_pkg::MODE_ADDR: v = s.mode;
			ads_pkg::TFB_ADDR:  v = s.tfb;
			ads_pkg::TONE_ADDR: v = s.tone;
			ads_pkg::SYNC_ADDR: v = s.syncc & ads_pkg::SYNC_RW_MASK;
			ads_pkg::STAT_ADDR: v[ads_pkg::STAT_ERR_BIT] = s.err_lat;
			default:            v = 8'h00;
		endcase
		return v;
	endfunction

	// All pins travel together through the synchroniser
	always_comb begin
		pins.standby_n = standby_n_i;
		pins.addr_sel  = addr_sel_i;
		pins.zc_det    = zc_det_i;
		pins.gain_req  = gain_req_i;
		pins.diag_req  = diag_req_i;
		pins.sync      = sync_i;
		pins.sda       = sda_i;
		pins.scl       = scl_i;
	end

	// Edge and condition detection only on second-stage samples
	always_comb begin
		scl_rise  = r.s2.scl & ~r.d.scl;
		scl_fall  = ~r.s2.scl & r.d.scl;
		bus_start = r.s2.scl & r.d.scl & r.d.sda & ~r.s2.sda;
		bus_stop  = r.s2.scl & r.d.scl & ~r.d.sda & r.s2.sda;
		sync_rise = r.s2.sync & ~r.d.sync;
		byte_in   = {r.shf[6:0], r.s2.sda};
		own_addr  = {ads_pkg::I2C_BASE_ADDR[6:2], r.s2.addr_sel};
		err_raw   = ~r.syncc[ads_pkg::SYNC_CTRL_BIT] & ~r.syncc[ads_pkg::SYNC_SKIP_BIT]
		          & r.sync_bad;
		case (r.tfb[ads_pkg::TFB_ZCW_LSB +: 2])
			2'h0:    zc_load = 18'(ads_pkg::ZC_WAIT_20_CYC);
			2'h1:    zc_load = ZC_WAIT_80_CYC;
			2'h2:    zc_load = ZC_WAIT_320_CYC;
			default: zc_load = ZC_WAIT_1280_CYC;
		endcase
	end

	// Next-state logic for the whole block
	always_comb begin
		n         = r;
		n.s1      = pins;
		n.s2      = r.s1;
		n.d       = r.s2;
		n.sda_out = 1'b0;
		n.gain_step = 1'b0;

		// Control bus slave: pointer byte first, then data with auto-increment
		if (bus_start) begin
			n.st     = ads_pkg::ADS_ADDR;
			n.bitc   = 3'h0;
			n.sda_oe = 1'b0;
		end else if (bus_stop) begin
			n.st     = ads_pkg::ADS_IDLE;
			n.sda_oe = 1'b0;
		end else begin
			case (r.st)
				ads_pkg::ADS_IDLE: begin
					n.sda_oe = 1'b0;
				end
				ads_pkg::ADS_ADDR: begin
					if (scl_rise) begin
						n.shf  = byte_in;
						n.bitc = r.bitc + 3'h1;
						if (r.bitc == ads_pkg::I2C_LAST_BIT) begin
							n.rw    = r.s2.sda;
							n.first = 1'b1;
							n.st    = (r.shf[6:0] == own_addr) ? ads_pkg::ADS_ACK
							                                   : ads_pkg::ADS_IDLE;
						end
					end
				end
				ads_pkg::ADS_ACK: begin
					if (scl_fall) begin
						n.sda_oe = 1'b1;
						n.st     = ads_pkg::ADS_ACK_HOLD;
					end
				end
				ads_pkg::ADS_ACK_HOLD: begin
					if (scl_fall) begin
						n.bitc = 3'h0;
						if (r.rw) begin
							n.shf    = reg_read(r, r.ptr);
							n.sda_oe = ~n.shf[ads_pkg::I2C_LAST_BIT];
							n.ptr    = r.ptr + 8'h01;
							n.st     = ads_pkg::ADS_RD;
							// Status read clears the latched error; a new error still wins
							if (r.ptr == ads_pkg::STAT_ADDR) begin
								n.err_lat = 1'b0;
							end
						end else begin
							n.sda_oe = 1'b0;
							n.st     = ads_pkg::ADS_WR;
						end
					end
				end
				ads_pkg::ADS_WR: begin
					if (scl_rise) begin
						n.shf  = byte_in;
						n.bitc = r.bitc + 3'h1;
						if (r.bitc == ads_pkg::I2C_LAST_BIT) begin
							n.st = ads_pkg::ADS_ACK;
							if (r.first) begin
								n.first = 1'b0;
								n.ptr   = byte_in;
							end else begin
								n.ptr = r.ptr + 8'h01;
								case (r.ptr)
									ads_pkg::MODE_ADDR: n.mode = byte_in;
									ads_pkg::TFB_ADDR:  n.tfb  = byte_in;
									ads_pkg::TONE_ADDR: n.tone = byte_in;
									ads_pkg::SYNC_ADDR: n.syncc = byte_in
									                    & ads_pkg::SYNC_RW_MASK;
									default:            n.tone = r.tone;
								endcase
							end
						end
					end
				end
				ads_pkg::ADS_RD: begin
					if (scl_fall) begin
						if (r.bitc == ads_pkg::I2C_LAST_BIT) begin
							n.sda_oe = 1'b0;
							n.st     = ads_pkg::ADS_RD_ACK;
						end else begin
							n.shf    = {r.shf[6:0], 1'b0};
							n.sda_oe = ~r.shf[6];
							n.bitc   = r.bitc + 3'h1;
						end
					end
				end
				ads_pkg::ADS_RD_ACK: begin
					// A not-acknowledge ends the read; an acknowledge fetches the next byte
					if (scl_rise) begin
						n.st = r.s2.sda ? ads_pkg::ADS_IDLE : ads_pkg::ADS_ACK_HOLD;
					end
				end
				default: begin
					n.st     = ads_pkg::ADS_IDLE;
					n.sda_oe = 1'b0;
				end
			endcase
		end

		// Phase-clock period watch in target mode; saturating so a dead clock stays flagged
		if (r.syncc[ads_pkg::SYNC_CTRL_BIT] | r.syncc[ads_pkg::SYNC_SKIP_BIT]) begin
			n.perc     = 8'h00;
			n.sync_bad = 1'b0;
		end else if (sync_rise) begin
			n.perc     = 8'h00;
			n.sync_bad = (r.perc < ads_pkg::SYNC_MIN_CYC) | (r.perc >= ads_pkg::SYNC_MAX_CYC);
		end else if (r.perc >= ads_pkg::SYNC_MAX_CYC) begin
			n.sync_bad = 1'b1;
		end else begin
			n.perc = r.perc + 8'h01;
		end

		// Error report: latch is set-dominant over the status-read clear
		if (err_raw & r.syncc[ads_pkg::SYNC_LATCH_BIT]) begin
			n.err_lat = 1'b1;
		end
		n.err = ~r.syncc[ads_pkg::SYNC_MASK_BIT]
		      & (r.syncc[ads_pkg::SYNC_LATCH_BIT] ? (r.err_lat | err_raw) : err_raw);

		// Controller mode drives the phase clock from a divider; the new role is used so that
		// the pin data drops in the same cycle as its enable and never leaks into target mode
		if (n.syncc[ads_pkg::SYNC_CTRL_BIT]) begin
			if (r.divc >= ads_pkg::SYNC_HALF_CYC - 8'h01) begin
				n.divc     = 8'h00;
				n.sync_drv = ~r.sync_drv;
			end else begin
				n.divc = r.divc + 8'h01;
			end
		end else begin
			n.divc     = 8'h00;
			n.sync_drv = 1'b0;
		end

		// Gain step waits for a zero crossing, but no longer than the chosen wait
		if (r.tfb[ads_pkg::TFB_OFF_BIT]) begin
			n.zc_busy = 1'b0;
		end else if (r.zc_busy) begin
			if (r.s2.zc_det | (r.zc_cnt == 18'h00000)) begin
				n.zc_busy   = 1'b0;
				n.gain_step = 1'b1;
			end else begin
				n.zc_cnt = r.zc_cnt - 18'h00001;
			end
		end else if (r.s2.gain_req & ~r.d.gain_req) begin
			if (r.tfb[ads_pkg::TFB_ZCBYP_BIT]) begin
				n.gain_step = 1'b1;
			end else begin
				n.zc_busy = 1'b1;
				n.zc_cnt  = zc_load;
			end
		end

		// Bridge pairing and switching rate take effect only in standby
		if (~r.s2.standby_n) begin
			n.paralleled_bridge_mode = {r.mode[ads_pkg::MODE_PBTL34_BIT], r.mode[ads_pkg::MODE_PBTL12_BIT]};
			if (r.mode[ads_pkg::MODE_FSW_LSB +: 2] != 2'h3) begin
				n.fsw = r.mode[ads_pkg::MODE_FSW_LSB +: 2];
			end
		end

		// A paired bridge runs diagnostics on both of its channels together
		for (int p = 0; p < 2; p++) begin
			n.diag_run[2*p +: 2] = r.paralleled_bridge_mode[p] ? {2{|r.s2.diag_req[2*p +: 2]}}
			                                 : r.s2.diag_req[2*p +: 2];
		end
	end

	// State register
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			r          <= '0;
			r.s1.scl   <= 1'b1;
			r.s1.sda   <= 1'b1;
			r.s2.scl   <= 1'b1;
			r.s2.sda   <= 1'b1;
			r.d.scl    <= 1'b1;
			r.d.sda    <= 1'b1;
			r.s1.standby_n <= 1'b1;
			r.s2.standby_n <= 1'b1;
			r.d.standby_n  <= 1'b1;
			r.st       <= ads_pkg::ADS_IDLE;
			r.mode     <= ads_pkg::MODE_RST;
			r.tfb      <= ads_pkg::TFB_RST;
			r.tone     <= ads_pkg::TONE_RST;
			r.syncc    <= ads_pkg::SYNC_RST;
			r.fsw      <= ads_pkg::FSW_2M1;
		end else begin
			r <= n;
		end
	end

	// Outputs straight from state
	assign sda_o       = r.sda_out;
	assign sda_oe_o    = r.sda_oe;
	assign sync_o      = r.sync_drv;
	assign sync_oe_o   = r.syncc[ads_pkg::SYNC_CTRL_BIT];
	assign sync_err_o  = r.err;
	assign gain_step_o = r.gain_step;
	assign diag_run_o  = r.diag_run;
	assign paralleled_bridge_mode_o      = r.paralleled_bridge_mode;
	assign line_drv_o  = r.mode[ads_pkg::MODE_LD_LSB +: 4];
	assign fsw_sel_o   = r.fsw;
	assign tone_freq_o = r.tone;

endmodule // ads_config

// ==== ads_config_chk.sv ====
// Port-level checks of the amplifier configuration block, bound into the design
`timescale 1ns/100ps
module ads_config_chk (
	input wire logic       sys_clk_i,
	input wire logic       rst_i,
	input wire logic       scl_i,
	input wire logic       standby_n_i,
	input wire logic       sync_o,
	input wire logic       sync_oe_o,
	input wire logic       gain_step_o,
	input wire logic [3:0] diag_req_i,
	input wire logic [3:0] diag_run_o,
	input wire logic [1:0] paralleled_bridge_mode_o,
	input wire logic [1:0] fsw_sel_o,
	input wire logic [3:0] line_drv_o,
	input wire logic [7:0] tone_freq_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	// Controller clock: eight cycles high, then low, unless the role is dropped
	sequence s_high_phase;
		sync_o [*8];
	endsequence
	sequence s_low_start;
		!sync_o;
	endsequence
	a_ctrl_period: assert property (
		$rose(sync_o) |-> (s_high_phase ##1 s_low_start) or (##[0:8] !sync_oe_o))
		else $error("controller clock half period wrong");
	a_tgt_quiet: assert property (!sync_oe_o |-> !sync_o)
		else $error("phase clock driven in target mode");
	a_reset_vals: assert property (
		$fell(rst_i) |-> tone_freq_o == 8'h32 && fsw_sel_o == 2'h1 && paralleled_bridge_mode_o == 2'h0)
		else $error("wrong outputs after reset");
	a_fsw_legal: assert property (fsw_sel_o != 2'h3)
		else $error("undefined switching frequency");
	// Pairing and rate may only move while the standby pin is low
	a_pair_hold: assert property (
		standby_n_i [*5] |-> $stable(paralleled_bridge_mode_o) && $stable(fsw_sel_o))
		else $error("pairing changed outside standby");
	a_diag_quiet: assert property ((diag_req_i == 4'h0) [*6] |-> diag_run_o == 4'h0)
		else $error("diagnostic runs without request");
	a_gain_pulse: assert property (gain_step_o |=> !gain_step_o)
		else $error("gain step longer than one cycle");
	// Registers only load at an SCL high phase of a bus write
	a_tone_write: assert property ($changed(tone_freq_o) |-> scl_i)
		else $error("tone code changed outside a write");
	a_mode_write: assert property ($changed(line_drv_o) |-> scl_i)
		else $error("line driver mode changed outside a write");
endmodule // ads_config_chk

bind ads_config ads_config_chk u_chk (.sys_clk_i, .rst_i, .scl_i, .standby_n_i, .sync_o,
	.sync_oe_o, .gain_step_o, .diag_req_i, .diag_run_o, .paralleled_bridge_mode_o, .fsw_sel_o, .line_drv_o,
	.tone_freq_o);

// ==== ads_host.sv ====
// I2C host model that reaches the register bank over SCL and SDA
`timescale 1ns/100ps
module ads_host (
	input  wire logic clk_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_low_o
);
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// Phases of four cycles, twice the design's input sync depth
	task automatic bit_io(input logic b, output logic r);
		sda_low_o <= !b;
		wt(4);
		scl_o <= 1'b1;
		wt(4);
		r = sda_i;
		wt(4);
		scl_o <= 1'b0;
		wt(4);
	endtask
	// Start or repeated start: SDA falls while SCL is high
	task automatic start();
		sda_low_o <= 1'b0;
		wt(4);
		scl_o <= 1'b1;
		wt(8);
		sda_low_o <= 1'b1;
		wt(8);
		scl_o <= 1'b0;
		wt(4);
	endtask
	task automatic stop();
		sda_low_o <= 1'b1;
		wt(4);
		scl_o <= 1'b1;
		wt(8);
		sda_low_o <= 1'b0;
		wt(8);
	endtask
	// Eight bits MSB first, then the acknowledge slot
	task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic nak);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
			q[i] = r;
		end
		bit_io(1'b1, nak);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic nak);
		logic [7:0] q;
		logic       k0, k1, k2;
		start();
		xfer({ads_pkg::I2C_BASE_ADDR, 1'b0}, q, k0);
		xfer(a, q, k1);
		xfer(d, q, k2);
		stop();
		nak = k0 | k1 | k2;
	endtask
	// Pointer write, repeated start, one byte read ended by a NACK
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic nak);
		logic [7:0] q;
		logic       k0, k1, k2, k3;
		start();
		xfer({ads_pkg::I2C_BASE_ADDR, 1'b0}, q, k0);
		xfer(a, q, k1);
		start();
		xfer({ads_pkg::I2C_BASE_ADDR, 1'b1}, q, k2);
		xfer(8'hFF, d, k3);
		stop();
		nak = k0 | k1 | k2;
	endtask
endmodule // ads_host

// ==== testbench.sv ====
// Self-checking bench for the amplifier register bank and phase-clock logic
`timescale 1ns/100ps
module testbench;
	typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] r;} ads_row_t;
	logic       clk = 1'b0, rst, sync_in, sync_run;
	logic       stby_n, gain_req, zc;
	logic       scl, sda_low, sda, sda_o, sda_oe, sync_o, sync_oe, err, gstep, nak;
	logic [1:0] asel, paralleled_bridge_mode, fsw;
	logic [3:0] dreq, drun, ldrv;
	logic [7:0] tone, q;
	int         failures = 0, num_checks = 0, n;
	// Tone limits, reserved bits, line drive, unmapped pointer
	ads_row_t   rows [6] = '{'{8'h2A, 8'h03, 8'h03}, '{8'h2A, 8'h3C, 8'h3C},
		'{8'h2B, 8'hFF, 8'h93}, '{8'h2B, 8'h13, 8'h13}, '{8'h00, 8'h0A, 8'h0A},
		'{8'h11, 8'h55, 8'h00}};
	// Control value, error while clock absent, error after it returns
	logic [9:0] srow [4] = '{10'h00B, 10'h048, 10'h200, 10'h002};
	// Thermal register, zero cross, bounds of the wait in cycles
	int         gt [6][4] = '{'{8'h10, 0, 1, 10}, '{8'h00, 1, 1, 10}, '{8'h00, 0, 2000, 2010},
		'{8'h40, 0, 40, 50}, '{8'h80, 0, 80, 90}, '{8'hC0, 0, 160, 170}};
	// Open-drain SDA with pull-up
	assign sda = !(sda_low | (sda_oe & !sda_o));
	always #5 clk = !clk;
	// Phase clock at 160 ns, offset from the system clock; it stands still when stopped
	initial begin
		sync_in = 1'b0;
		#3;
		forever #80 if (sync_run) sync_in = !sync_in;
	end
	ads_config #(.ZC_WAIT_80_CYC(18'h00028), .ZC_WAIT_320_CYC(18'h00050),
		.ZC_WAIT_1280_CYC(18'h000A0)) DUT (
		.sys_clk_i  (clk),
		.rst_i      (rst),
		.scl_i      (scl),
		.sda_i      (sda),
		.sda_o      (sda_o),
		.sda_oe_o   (sda_oe),
		.addr_sel_i (asel),
		.standby_n_i(stby_n),
		.sync_i     (sync_in),
		.sync_o     (sync_o),
		.sync_oe_o  (sync_oe),
		.sync_err_o (err),
		.gain_req_i (gain_req),
		.zc_det_i   (zc),
		.gain_step_o(gstep),
		.diag_req_i (dreq),
		.diag_run_o (drun),
		.paralleled_bridge_mode_o     (paralleled_bridge_mode),
		.line_drv_o (ldrv),
		.fsw_sel_o  (fsw),
		.tone_freq_o(tone)
	);
	ads_host host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic test_done();
		$display("Checks %0d, mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Cycles until the gain step pulse, bounded so a lost pulse cannot hang the run
	task automatic wait_step(output int c);
		c = 0;
		do begin
			@(posedge clk);
			c++;
			if (c > 3000) begin
				failures++;
				test_done();
			end
		end while (gstep !== 1'b1);
	endtask
	initial begin
		rst      <= 1'b1;
		sync_run <= 1'b1;
		stby_n   <= 1'b1;
		gain_req <= 1'b0;
		zc       <= 1'b0;
		asel     <= 2'h0;
		dreq     <= 4'h0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		host.wt(8);
		foreach (rows[i]) begin
			host.wr(rows[i].a, rows[i].d, nak);
			chk({7'h00, nak}, 8'h00);
			host.rd(rows[i].a, q, nak);
			chk(q, rows[i].r);
			if (rows[i].a == ads_pkg::TONE_ADDR) chk(tone, rows[i].r);
			if (rows[i].a == ads_pkg::MODE_ADDR) chk({4'h0, ldrv}, rows[i].r);
		end
		chk({7'h00, sync_oe}, 8'h01);
		// Controller clock is high for half of any window that spans whole periods
		n = 0;
		repeat (32) begin
			@(posedge clk);
			if (sync_o === 1'b1) n++;
		end
		chk(8'(n), 8'h10);
		$display("Register rows done");
		// Wrong device address is not acknowledged and changes nothing
		asel <= 2'h1;
		host.wr(ads_pkg::TONE_ADDR, 8'h10, nak);
		chk({7'h00, nak}, 8'h01);
		chk(tone, 8'h3C);
		asel <= 2'h0;
		stby_n <= 1'b0;
		for (int i = 0; i < 3; i++) begin
			host.wr(ads_pkg::MODE_ADDR, 8'(i << 6 | (i + 1) << 4), nak);
			chk({4'h0, paralleled_bridge_mode, fsw}, 8'(((i + 1) << 2) | i));
		end
		dreq <= 4'h1;
		host.wt(8);
		chk({4'h0, drun}, 8'h03);
		dreq <= 4'h4;
		host.wt(8);
		chk({4'h0, drun}, 8'h0C);
		dreq <= 4'h0;
		// Undefined rate code is ignored, the previous rate stays
		host.wr(ads_pkg::MODE_ADDR, 8'hF0, nak);
		chk({4'h0, paralleled_bridge_mode, fsw}, 8'h0E);
		stby_n <= 1'b1;
		host.wr(ads_pkg::MODE_ADDR, 8'h00, nak);
		chk({6'h00, paralleled_bridge_mode}, 8'h03);
		$display("Pairing test done");
		foreach (srow[i]) begin
			host.wr(ads_pkg::SYNC_ADDR, srow[i][9:2], nak);
			host.rd(ads_pkg::STAT_ADDR, q, nak);
			host.wt(80);
			chk({7'h00, err}, 8'h00);
			sync_run <= 1'b0;
			host.wt(60);
			chk({7'h00, err}, {7'h00, srow[i][1]});
			sync_run <= 1'b1;
			host.wt(60);
			chk({7'h00, err}, {7'h00, srow[i][0]});
		end
		$display("Phase clock test done");
		for (int i = 0; i < 6; i++) begin
			host.wr(ads_pkg::TFB_ADDR, 8'(gt[i][0]), nak);
			zc <= 1'(gt[i][1]);
			gain_req <= 1'b1;
			wait_step(n);
			chk({7'h00, n inside {[gt[i][2] : gt[i][3]]}}, 8'h01);
			gain_req <= 1'b0;
			zc <= 1'b0;
			host.wt(4);
		end
		// Foldback off: a request must not produce any step
		host.wr(ads_pkg::TFB_ADDR, 8'h30, nak);
		gain_req <= 1'b1;
		n = 0;
		repeat (20) begin
			@(posedge clk);
			if (gstep !== 1'b0) n++;
		end
		chk(8'(n), 8'h00);
		gain_req <= 1'b0;
		host.wt(4);
		$display("Gain step test done");
		rst <= 1'b1;
		host.wt(3);
		rst <= 1'b0;
		@(posedge clk);
		chk({paralleled_bridge_mode, fsw, ldrv}, 8'h10);
		chk(tone, 8'h32);
		host.wt(8);
		host.rd(ads_pkg::TONE_ADDR, q, nak);
		chk(q, 8'h32);
		host.rd(ads_pkg::SYNC_ADDR, q, nak);
		chk(q, 8'h02);
		$display("Reset test done");
		test_done();
	end
endmodule // testbench
